// file: mpio_defs.vh
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH
`define MPIO_AW 8
`define MPIO_ADR_P1_LATCH 8'h01
`define MPIO_ADR_P3_LATCH 8'h03
`define MPIO_ADR_P4_LATCH 8'h04
`define MPIO_ADR_P6_LATCH 8'h06
`define MPIO_ADR_P1_DIR 8'h0B
`define MPIO_ADR_P3_DIR 8'h0C
`define MPIO_ADR_P4_DIR 8'h0D
`define MPIO_ADR_P6_DIR 8'h0E
`define MPIO_ADR_P3_ODS 8'h10
`define MPIO_ADR_P4_ODS 8'h11
`define MPIO_ADR_ADC_CTRL 8'h12
`define MPIO_ADC_DIS_BIT 4
`define MPIO_ADC_CH_LSB 0
`define MPIO_ADC_CH_W 2
`define MPIO_ADC_CTRL_RST 8'h10
`define MPIO_ZERO8 8'h00
`define MPIO_ZERO6 6'h00
`define MPIO_ZERO4 4'h0
`endif

// file: mpio_pin_sync.v
`timescale 1ns/1ns
// Three-stage synchroniser; the output moves only when stages two and three agree.
module mpio_pin_sync #(
    parameter W = 8
) (
    clk,
    nrst,
    pin_i,
    sync_o
);
input wire clk;
input wire nrst;
input wire [W-1:0] pin_i;
output wire [W-1:0] sync_o;
reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
reg [W-1:0] out_q;
genvar i;
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        s1_q <= {W{1'b0}};
        s2_q <= {W{1'b0}};
        s3_q <= {W{1'b0}};
    end else begin
        s1_q <= pin_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
end
generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                out_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                out_q[i] <= s3_q[i];
            end
        end
    end
endgenerate
assign sync_o = out_q;
endmodule // mpio_pin_sync

// file: mpio_ports.v
`timescale 1ns/1ns
`include "mpio_defs.vh"
module mpio_ports (
    clk,
    nrst,
    addr,
    wdata,
    wr_en,
    rd_en,
    rd_latch,
    rdata,
    p1_in,
    p1_out,
    p1_oe_n,
    p3_in,
    p3_out,
    p3_oe_n,
    p4_in,
    p4_out,
    p4_oe_n,
    p6_in,
    p6_out,
    p6_oe_n,
    ext_external_interrupt_zero,
    analog_input_disable,
    analog_channel_select,
    adc_start
);
input wire clk;
input wire nrst;
input wire [`MPIO_AW-1:0] addr;
input wire [7:0] wdata;
input wire wr_en;
input wire rd_en;
input wire rd_latch;
output reg [7:0] rdata;
input wire p1_in;
output wire p1_out;
output wire p1_oe_n;
input wire [7:0] p3_in;
output wire [7:0] p3_out;
output wire [7:0] p3_oe_n;
input wire [5:0] p4_in;
output wire [5:0] p4_out;
output wire [5:0] p4_oe_n;
input wire [3:0] p6_in;
output wire [3:0] p6_out;
output wire [3:0] p6_oe_n;
output wire ext_external_interrupt_zero;
output wire analog_input_disable;
output wire [`MPIO_ADC_CH_W-1:0] analog_channel_select;
output reg adc_start;

reg port1_output_latch_q;
reg port1_direction_q;
reg [7:0] port3_output_latch_q;
reg [7:0] port3_direction_q;
reg [7:0] port3_open_drain_sel_q;
reg [5:0] port4_output_latch_q;
reg [5:0] port4_direction_q;
reg [5:0] port4_open_drain_sel_q;
reg [3:0] port6_output_latch_q;
reg [3:0] port6_direction_q;
reg [7:0] adc_ctrl_q;
reg [7:0] rdata_d;
wire [18:0] pins_raw;
wire [18:0] pins_s;
wire p1_s;
wire [7:0] p3_s;
wire [5:0] p4_s;
wire [3:0] p6_s;
wire [7:0] p4_oe_full;
wire [7:0] p1_rd_value;
wire [7:0] p3_rd_value;
wire [7:0] p4_rd_value;
wire [3:0] p6_pin_view;
wire [7:0] p6_rd_value;

// Pad drive: oe_n low drives. Open-drain releases on latch one.
function [7:0] pad_oe_n;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] od;
    begin
        pad_oe_n = ~(dir & ~(od & latch));
    end
endfunction

// Pin level for outputs in push-pull is the latch; reads of pins stay live anyway.
function [7:0] pin_or_latch;
    input [7:0] pin;
    input [7:0] latch;
    input use_latch;
    begin
        pin_or_latch = use_latch ? latch : pin;
    end
endfunction

// Address match qualified by a strobe; every write decode uses it, while the read mux decodes addr alone.
function reg_hit;
    input strobe;
    input [`MPIO_AW-1:0] a;
    input [`MPIO_AW-1:0] target;
    begin
        reg_hit = strobe & (a == target);
    end
endfunction

// Every pin crosses through the same filter, so a read lags the pad by about four cycles.
assign pins_raw = {p6_in, p4_in, p3_in, p1_in};

mpio_pin_sync #(
    .W(19)
) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_i(pins_raw),
    .sync_o(pins_s)
);

assign p1_s = pins_s[0];
assign p3_s = pins_s[8:1];
assign p4_s = pins_s[14:9];
assign p6_s = pins_s[18:15];

// The interrupt input takes the filtered pin, so a one-cycle glitch never reaches it.
assign ext_external_interrupt_zero = p1_s;
assign p1_out = port1_output_latch_q;
// Ports one and six have no open-drain select and drive both levels.
assign p1_oe_n = ~port1_direction_q;
assign p3_out = port3_output_latch_q;
assign p3_oe_n = pad_oe_n(port3_direction_q, port3_output_latch_q, port3_open_drain_sel_q);
assign p4_out = port4_output_latch_q;
// The top two bits of the padded byte have no pin and are dropped.
assign p4_oe_full = pad_oe_n({2'b00, port4_direction_q}, {2'b00, port4_output_latch_q},
    {2'b00, port4_open_drain_sel_q});
assign p4_oe_n = p4_oe_full[5:0];
assign p6_out = port6_output_latch_q;
assign p6_oe_n = ~port6_direction_q;
assign analog_input_disable = adc_ctrl_q[`MPIO_ADC_DIS_BIT];
assign analog_channel_select = adc_ctrl_q[`MPIO_ADC_CH_LSB +: `MPIO_ADC_CH_W];

// Read values of the latch addresses; rd_latch marks the read half of a modify.
assign p1_rd_value = {7'h00, rd_latch ? port1_output_latch_q : p1_s};
assign p3_rd_value = pin_or_latch(p3_s, port3_output_latch_q, rd_latch);
assign p4_rd_value = pin_or_latch({2'b00, p4_s}, {2'b00, port4_output_latch_q},
    rd_latch);
// Pins read low while analog input is gated; a driven push-pull bit reads its latch.
assign p6_pin_view = (analog_input_disable ? `MPIO_ZERO4 : p6_s) |
    (port6_direction_q & port6_output_latch_q);
// Latch-zero bits read zero, which also covers the bits set for analog input.
assign p6_rd_value = {`MPIO_ZERO4, port6_output_latch_q &
    (rd_latch ? 4'hF : p6_pin_view)};

// The bus master performs a modify as a latch read then a full-byte write.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        port1_output_latch_q <= 1'b0;
        port1_direction_q <= 1'b0;
    end else begin
        if (reg_hit(wr_en, addr, `MPIO_ADR_P1_LATCH)) begin
            port1_output_latch_q <= wdata[0];
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P1_DIR)) begin
            port1_direction_q <= wdata[0];
        end
    end
end

// Port three carries the open-drain select beside its latch and direction.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        port3_output_latch_q <= `MPIO_ZERO8;
        port3_direction_q <= `MPIO_ZERO8;
        port3_open_drain_sel_q <= `MPIO_ZERO8;
    end else begin
        if (reg_hit(wr_en, addr, `MPIO_ADR_P3_LATCH)) begin
            port3_output_latch_q <= wdata;
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P3_DIR)) begin
            port3_direction_q <= wdata;
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P3_ODS)) begin
            port3_open_drain_sel_q <= wdata;
        end
    end
end

// Port four is six bits wide; the top two bits of a written byte are dropped.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        port4_output_latch_q <= `MPIO_ZERO6;
        port4_direction_q <= `MPIO_ZERO6;
        port4_open_drain_sel_q <= `MPIO_ZERO6;
    end else begin
        if (reg_hit(wr_en, addr, `MPIO_ADR_P4_LATCH)) begin
            port4_output_latch_q <= wdata[5:0];
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P4_DIR)) begin
            port4_direction_q <= wdata[5:0];
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P4_ODS)) begin
            port4_open_drain_sel_q <= wdata[5:0];
        end
    end
end

// Port six has no open-drain select; its pins are push-pull or gated analog inputs.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        port6_output_latch_q <= `MPIO_ZERO4;
        port6_direction_q <= `MPIO_ZERO4;
    end else begin
        if (reg_hit(wr_en, addr, `MPIO_ADR_P6_LATCH)) begin
            port6_output_latch_q <= wdata[3:0];
        end
        if (reg_hit(wr_en, addr, `MPIO_ADR_P6_DIR)) begin
            port6_direction_q <= wdata[3:0];
        end
    end
end

// The converter control byte is stored whole; only the flag and channel act here.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        adc_ctrl_q <= `MPIO_ADC_CTRL_RST;
    end else if (reg_hit(wr_en, addr, `MPIO_ADR_ADC_CTRL)) begin
        adc_ctrl_q <= wdata;
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        adc_start <= 1'b0;
    end else begin
        // Start only on the one-to-zero edge of the disable flag.
        adc_start <= reg_hit(wr_en, addr, `MPIO_ADR_ADC_CTRL) &
            adc_ctrl_q[`MPIO_ADC_DIS_BIT] & ~wdata[`MPIO_ADC_DIS_BIT];
    end
end

always @* begin
    rdata_d = `MPIO_ZERO8;
    case (addr)
        `MPIO_ADR_P1_LATCH: rdata_d = p1_rd_value;
        `MPIO_ADR_P1_DIR: rdata_d = {7'h00, port1_direction_q};
        `MPIO_ADR_P3_LATCH: rdata_d = p3_rd_value;
        `MPIO_ADR_P3_DIR: rdata_d = port3_direction_q;
        `MPIO_ADR_P3_ODS: rdata_d = port3_open_drain_sel_q;
        `MPIO_ADR_P4_LATCH: rdata_d = p4_rd_value;
        `MPIO_ADR_P4_DIR: rdata_d = {2'b00, port4_direction_q};
        `MPIO_ADR_P4_ODS: rdata_d = {2'b00, port4_open_drain_sel_q};
        `MPIO_ADR_P6_LATCH: rdata_d = p6_rd_value;
        `MPIO_ADR_P6_DIR: rdata_d = {4'h0, port6_direction_q};
        `MPIO_ADR_ADC_CTRL: rdata_d = adc_ctrl_q;
        default: rdata_d = `MPIO_ZERO8;
    endcase
end

// Read data stand one cycle and fall back to zero, so a stale byte never looks fresh.
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rdata <= `MPIO_ZERO8;
    end else if (rd_en) begin
        rdata <= rdata_d;
    end else begin
        rdata <= `MPIO_ZERO8;
    end
end
endmodule // mpio_ports

// file: mpio_ports_properties.sv
`timescale 1ns/1ns
module mpio_ports_chk (
    input wire clk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire rd_latch,
    input wire [7:0] rdata,
    input wire [7:0] p3_out,
    input wire [3:0] p6_out,
    input wire p1_oe_n,
    input wire analog_input_disable,
    input wire adc_start
);
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
property p_wr3; wr_en && addr == 8'h03 |=> p3_out == $past(wdata); endproperty
a_wr3: assert property (p_wr3) else $error("p3 latch write lost");
property p_wr6; wr_en && addr == 8'h06 |=> p6_out == $past(wdata[3:0]); endproperty
a_wr6: assert property (p_wr6) else $error("p6 latch write lost");
property p_rmw; rd_en && rd_latch && addr == 8'h03 |=> rdata == p3_out; endproperty
a_rmw: assert property (p_rmw) else $error("modify read not latch");
property p_z6; rd_en && addr == 8'h06 |=> (rdata & {4'hF, ~p6_out}) == 8'h00; endproperty
a_z6: assert property (p_z6) else $error("p6 zero latch read high");
property p_go; adc_start |-> $past(wr_en && addr == 8'h12 && !wdata[4]); endproperty
a_go: assert property (p_go) else $error("stray conversion start");
property p_dis; wr_en && addr == 8'h12 |=> analog_input_disable == $past(wdata[4]); endproperty
a_dis: assert property (p_dis) else $error("disable flag write lost");
property p_rst; $rose(nrst) |-> p3_out == 8'h00 && p6_out == 4'h0 && analog_input_disable; endproperty
a_rst: assert property (p_rst) else $error("bad reset state");
property p_dir1; wr_en && addr == 8'h0B |=> p1_oe_n == !$past(wdata[0]); endproperty
a_dir1: assert property (p_dir1) else $error("p1 direction wrong");
endmodule // mpio_ports_chk

// file: mpio_pad.sv
`timescale 1ns/1ns
// The outside keeps its own level wherever the port lets the pin go.
module mpio_pad #(parameter W = 8) (
    input wire [W-1:0] oe_n,
    input wire [W-1:0] drv,
    input wire [W-1:0] ext,
    output wire [W-1:0] pin
);
assign pin = (~oe_n & drv) | (oe_n & ext);
endmodule // mpio_pad

// file: mpio_ports_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected %0t got %h exp %h", $time, a, b); end end
module mpio_ports_tb;
reg clk = 0, nrst = 0, wr_en = 0, rd_en = 0, rd_latch = 0, x1 = 0;
reg [7:0] addr = 8'h00, wdata = 8'h00, x3 = 8'h00;
reg [5:0] x4 = 6'h00;
reg [3:0] x6 = 4'h0;
wire [7:0] rdata, p3_in, p3_out, p3_oe_n;
wire [5:0] p4_in, p4_out, p4_oe_n;
wire [3:0] p6_in, p6_out, p6_oe_n;
wire [1:0] ch;
wire p1_in, p1_out, p1_oe_n, ext_external_interrupt_zero, dis, adc_start;
reg [7:0] m [0:255];
int err_total = 0, n_tests = 0, i;
mpio_ports mpio_ports_i(.clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rd_latch, .rdata,
    .p1_in, .p1_out, .p1_oe_n, .p3_in, .p3_out, .p3_oe_n, .p4_in, .p4_out, .p4_oe_n,
    .p6_in, .p6_out, .p6_oe_n, .ext_external_interrupt_zero, .analog_input_disable(dis),
    .analog_channel_select(ch), .adc_start);
mpio_pad #(1) pad1_i(.oe_n(p1_oe_n), .drv(p1_out), .ext(x1), .pin(p1_in));
mpio_pad #(8) pad3_i(.oe_n(p3_oe_n), .drv(p3_out), .ext(x3), .pin(p3_in));
mpio_pad #(6) pad4_i(.oe_n(p4_oe_n), .drv(p4_out), .ext(x4), .pin(p4_in));
mpio_pad #(4) pad6_i(.oe_n(p6_oe_n), .drv(p6_out), .ext(x6), .pin(p6_in));
initial forever #5 clk = ~clk;
// Pin level: a released open-drain bit shows the outside level.
function [7:0] pv(input [7:0] d, o, l, e);
    reg [7:0] v;
    v = d & ~(o & l);
    pv = (v & l) | (~v & e);
endfunction
task wr(input [7:0] a, input [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    m[a] = v;
endtask
task rd(input [7:0] a, input l, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    rd_latch <= l;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 `CHK(rdata, e)
endtask
task wrap_up;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
initial begin
    #300000;
    err_total++;
    wrap_up;
end
initial begin
    void'($urandom(15));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 19; i++) rd(8'(i), 0, i == 18 ? 8'h10 : 8'h00);
    $display("test reset done");
    repeat (8) begin
        @(posedge clk);
        x3 <= 8'($urandom);
        x4 <= 6'($urandom);
        wr(8'h0C, 8'($urandom));
        wr(8'h10, 8'($urandom));
        wr(8'h03, 8'($urandom));
        wr(8'h0D, 8'($urandom) & 8'h3F);
        wr(8'h11, 8'($urandom) & 8'h3F);
        wr(8'h04, 8'($urandom) & 8'h3F);
        repeat (6) @(posedge clk);
        #1 `CHK(p3_oe_n, ~(m[8'h0C] & ~(m[8'h10] & m[8'h03])))
        `CHK(p4_oe_n, ~(m[8'h0D][5:0] & ~(m[8'h11][5:0] & m[8'h04][5:0])))
        `CHK(p4_out, m[8'h04][5:0])
        rd(8'h03, 0, pv(m[8'h0C], m[8'h10], m[8'h03], x3));
        rd(8'h04, 0, pv(m[8'h0D], m[8'h11], m[8'h04], {2'b00, x4}));
        rd(8'h04, 1, m[8'h04]);
        rd(8'h03, 1, m[8'h03]);
        wr(8'h03, m[8'h03] ^ 8'h81);
        #1 `CHK(p3_out, m[8'h03])
    end
    wr(8'h03, 8'hFF);
    #1 `CHK(p3_out, 8'hFF)
    $display("test open drain done");
    @(posedge clk);
    x1 <= 1'b1;
    repeat (6) @(posedge clk);
    #1 `CHK(ext_external_interrupt_zero, 1'b1)
    wr(8'h0B, 8'h01);
    repeat (6) @(posedge clk);
    #1 `CHK(ext_external_interrupt_zero, 1'b0)
    $display("test one bit done");
    @(posedge clk);
    x6 <= 4'hA;
    wr(8'h0E, 8'h01);
    #1 `CHK(p6_oe_n, 4'hE)
    wr(8'h06, 8'h0D);
    repeat (6) @(posedge clk);
    rd(8'h06, 0, 8'h01);
    wr(8'h12, 8'h02);
    #1 `CHK(adc_start, 1'b1)
    `CHK(ch, 2'h2)
    repeat (6) @(posedge clk);
    rd(8'h06, 0, 8'h09);
    $display("test analog done");
    wrap_up;
end
endmodule // mpio_ports_tb
bind mpio_ports mpio_ports_chk chk_i(.clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rd_latch,
    .rdata, .p3_out, .p6_out, .p1_oe_n, .analog_input_disable, .adc_start);
